// file: verilog/peripheral_write_protect_control.sv
// APB register block holding write-protect bits for two access controllers
// Register map, byte addresses on the peripheral bus:
//   first controller, clear view and set view
//   second controller, clear view and set view
// Ones written through a set view protect, through a clear view unprotect
// Both views of one controller read back the same protection word
// Any other address answers with pslverr and changes nothing
//
// Timing and limits:
//   every access takes one wait state; bus outputs come from flops
//   protect outputs follow a committed write one edge later
//   no lock bit: any bus master may change protection at any time
//   set and clear are separate words, so one write never does both
//   a read of an unmapped address returns zero
//   protect levels are flops, so no combinational path leaves the block
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module peripheral_write_protect_control
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [write_protect_pkg::ADDR_W-1:0] paddr,
    input wire logic [write_protect_pkg::DATA_W-1:0] pwdata,
    output logic [write_protect_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic trace_buffer_protect,
    output logic port_protect,
    output logic flash_controller_protect,
    output logic debug_unit_protect,
    output logic [7:0] timer_protect,
    output logic [5:0] serial_interface_protect,
    output logic event_system_protect,
    output logic converter_protect
);
    import write_protect_pkg::*;

    // =====================================================================
    // Decode helpers
    // One compare per register; strobes, error and read mux share it
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
        addr_hit = (addr == ofs);
    endfunction : addr_hit

    // Either view of the first controller
    function automatic logic first_hit(input logic [ADDR_W-1:0] addr);
        first_hit = addr_hit(addr, OFS_FIRST_SET) || addr_hit(addr, OFS_FIRST_CLEAR);
    endfunction : first_hit

    // Either view of the second controller
    function automatic logic second_hit(input logic [ADDR_W-1:0] addr);
        second_hit = addr_hit(addr, OFS_SECOND_SET) || addr_hit(addr, OFS_SECOND_CLEAR);
    endfunction : second_hit

    // =====================================================================
    // Internal signals
    // Bus phase decode
    logic access;
    logic answer;
    logic commit;
    logic mapped;
    // Per-register write strobes, one cycle wide
    logic first_set_wr;
    logic first_clear_wr;
    logic second_set_wr;
    logic second_clear_wr;
    // Protection words as the banks hold them
    logic [31:0] first_state;
    logic [31:0] second_state;
    // Read word latched into prdata at the answer edge
    logic [31:0] next_prdata;

    // =====================================================================
    // Bus phases
    // Access phase of a transfer
    assign access = psel && penable;
    // First access edge: the slave latches its answer here
    assign answer = access && !pready;
    // A write lands only at the edge where pready is sampled high
    assign commit = access && pready && pwrite;

    // =====================================================================
    // Write strobes
    // Set and clear live at different addresses, so they never collide
    assign first_set_wr = commit && addr_hit(paddr, OFS_FIRST_SET);
    assign first_clear_wr = commit && addr_hit(paddr, OFS_FIRST_CLEAR);
    assign second_set_wr = commit && addr_hit(paddr, OFS_SECOND_SET);
    assign second_clear_wr = commit && addr_hit(paddr, OFS_SECOND_CLEAR);
    // Zero bits in the written word are masked inside each bank
    // Unmapped addresses raise no strobe, so such writes are dropped
    assign mapped = first_hit(paddr) || second_hit(paddr);

    // =====================================================================
    // Protection banks
    // Only implemented bits are flops; every other bit reads as zero
    // First controller: trace buffer, port, flash controller, debug unit
    protect_bank #(
        .IMPL_MASK(FIRST_IMPL_MASK),
        .RESET_VALUE(FIRST_RESET)
    ) u_first (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .set_wr(first_set_wr),
        .clear_wr(first_clear_wr),
        .wdata(pwdata),
        .protect(first_state)
    );

    // Second controller: timers, serial interfaces, event system, converter
    // No bit of it is protected after reset
    protect_bank #(
        .IMPL_MASK(SECOND_IMPL_MASK),
        .RESET_VALUE(SECOND_RESET)
    ) u_second (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .set_wr(second_set_wr),
        .clear_wr(second_clear_wr),
        .wdata(pwdata),
        .protect(second_state)
    );

    // =====================================================================
    // Read mux: both set and clear views show the same state
    // Combinational, so a read sees a write that landed the edge before
    // Unmapped addresses fall through to zero
    always_comb
    begin
        next_prdata = ZERO_WORD;
        if (first_hit(paddr))
            next_prdata = first_state;
        else if (second_hit(paddr))
            next_prdata = second_state;
    end

    // =====================================================================
    // Bus answer, one wait state so every bus output is a flop
    // Costs a cycle per access but keeps the read mux off the prdata path
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            pready <= 1'h0;
        else
            pready <= answer; // High for exactly one cycle
    end

    // Error pulse travels with pready
    // Writes to unmapped words are dropped by the strobe decode
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            pslverr <= 1'h0;
        else
            pslverr <= answer && !mapped;
    end

    // Read data stands only while pready is high
    // Writes answer with zero so a stale word never leaks out
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            prdata <= ZERO_WORD;
        else if (answer && !pwrite)
            prdata <= next_prdata;
        else
            prdata <= ZERO_WORD;
    end

    // =====================================================================
    // First controller outputs, registered copies of the bank
    // Adds one cycle of lag after a write; peripherals see a glitch-free level
    // Reset levels match the bank's reset word
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            trace_buffer_protect <= FIRST_RESET[BIT_TRACE_BUFFER];
            port_protect <= FIRST_RESET[BIT_PORT];
            flash_controller_protect <= FIRST_RESET[BIT_FLASH_CTRL];
            debug_unit_protect <= FIRST_RESET[BIT_DEBUG_UNIT];
        end
        else
        begin
            trace_buffer_protect <= first_state[BIT_TRACE_BUFFER];
            port_protect <= first_state[BIT_PORT];
            flash_controller_protect <= first_state[BIT_FLASH_CTRL];
            debug_unit_protect <= first_state[BIT_DEBUG_UNIT];
        end
    end

    // =====================================================================
    // Second controller outputs, same one-cycle lag as the first
    // Timer and serial fields keep their bit order from the bank word
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            timer_protect <= SECOND_RESET[TIMER_HI:TIMER_LO];
            serial_interface_protect <= SECOND_RESET[SERIAL_HI:SERIAL_LO];
            event_system_protect <= SECOND_RESET[BIT_EVENT_SYSTEM];
            converter_protect <= SECOND_RESET[BIT_CONVERTER];
        end
        else
        begin
            timer_protect <= second_state[TIMER_HI:TIMER_LO];
            serial_interface_protect <= second_state[SERIAL_HI:SERIAL_LO];
            event_system_protect <= second_state[BIT_EVENT_SYSTEM];
            converter_protect <= second_state[BIT_CONVERTER];
        end
    end
endmodule : peripheral_write_protect_control
`default_nettype wire

// file: verilog/write_protect_pkg.sv
// Constants for the peripheral write-protect controller
`default_nettype none
package write_protect_pkg;
    // =====================================================================
    // Bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // =====================================================================
    // Register byte offsets
    localparam logic [7:0] OFS_FIRST_CLEAR = 8'h00;
    localparam logic [7:0] OFS_FIRST_SET = 8'h04;
    localparam logic [7:0] OFS_SECOND_CLEAR = 8'h10;
    localparam logic [7:0] OFS_SECOND_SET = 8'h14;

    // =====================================================================
    // First controller field positions and reset value
    localparam int BIT_DEBUG_UNIT = 1;
    localparam int BIT_FLASH_CTRL = 2;
    localparam int BIT_PORT = 3;
    localparam int BIT_TRACE_BUFFER = 6;
    localparam logic [31:0] FIRST_IMPL_MASK = 32'h0000_004E;
    localparam logic [31:0] FIRST_RESET = 32'h0000_0002;

    // =====================================================================
    // Second controller field positions and reset value
    localparam int BIT_EVENT_SYSTEM = 1;
    localparam int SERIAL_LO = 2;
    localparam int SERIAL_HI = 7;
    localparam int TIMER_LO = 8;
    localparam int TIMER_HI = 15;
    localparam int BIT_CONVERTER = 16;
    localparam logic [31:0] SECOND_IMPL_MASK = 32'h0001_FFFE;
    localparam logic [31:0] SECOND_RESET = 32'h0000_0000;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : write_protect_pkg
`default_nettype wire

// file: verilog/protect_bank.sv
// One bank of write-protect bits with set and clear strobes
`timescale 1ns/10ps
`default_nettype none
module protect_bank
#(
    parameter logic [31:0] IMPL_MASK = 32'h0000_0000,
    parameter logic [31:0] RESET_VALUE = 32'h0000_0000
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic set_wr,
    input wire logic clear_wr,
    input wire logic [31:0] wdata,
    output logic [31:0] protect
);
    // =====================================================================
    // Per-bit protect flops
    genvar i;
    generate
        for (i = 0; i < 32; i++)
        begin : g_bit
            if (IMPL_MASK[i])
            begin : g_impl
                logic held;
                // A zero in the written word leaves the bit alone
                always_ff @(posedge clk_sys or negedge nrst)
                begin
                    if (!nrst)
                        held <= RESET_VALUE[i];
                    else if (set_wr && wdata[i])
                        held <= 1'h1;
                    else if (clear_wr && wdata[i])
                        held <= 1'h0;
                end
                // One flop per bit, so the word has a single driver per bit
                assign protect[i] = held;
            end
            else
            begin : g_unused
                assign protect[i] = 1'b0;
            end
        end
    endgenerate
endmodule : protect_bank
`default_nettype wire

// file: tb/write_protect_sva.sv
// Checker for the write-protect controller ports
`timescale 1ns/10ps
`default_nettype none
module write_protect_sva
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [write_protect_pkg::ADDR_W-1:0] paddr,
    input wire logic [write_protect_pkg::DATA_W-1:0] pwdata,
    input wire logic [write_protect_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trace_buffer_protect,
    input wire logic port_protect,
    input wire logic flash_controller_protect,
    input wire logic debug_unit_protect,
    input wire logic [7:0] timer_protect,
    input wire logic [5:0] serial_interface_protect,
    input wire logic event_system_protect,
    input wire logic converter_protect
);
    import write_protect_pkg::*;
    // =====
    // Helpers: state words as software sees them
    logic [31:0] st1, st2, ex1, ex2;
    logic acc, wr;
    assign st1 = {25'h0, trace_buffer_protect, 2'h0, port_protect, flash_controller_protect, debug_unit_protect, 1'h0};
    assign st2 = {15'h0, converter_protect, timer_protect, serial_interface_protect, event_system_protect, 1'h0};
    // Ones act, zeros leave bits alone
    assign ex1 = paddr == OFS_FIRST_SET ? st1 | (pwdata & FIRST_IMPL_MASK) : st1 & ~(pwdata & FIRST_IMPL_MASK);
    assign ex2 = paddr == OFS_SECOND_SET ? st2 | (pwdata & SECOND_IMPL_MASK) : st2 & ~(pwdata & SECOND_IMPL_MASK);
    assign acc = psel && penable && !pready;
    assign wr = pready && pwrite && !pslverr;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // =====
    // Bus timing and register contents
    wait_state_a: assert property (acc |=> pready ##1 !pready) else $error("pready not after one wait");
    ready_cause_a: assert property (pready |-> $past(acc)) else $error("pready without access");
    unmapped_err_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h10, 8'h14}))
        else $error("pslverr wrong");
    first_read_a: assert property (pready && !pwrite && paddr inside {8'h00, 8'h04} |-> prdata == st1)
        else $error("first read wrong");
    second_read_a: assert property (pready && !pwrite && paddr inside {8'h10, 8'h14} |-> prdata == st2)
        else $error("second read wrong");
    first_write_a: assert property (wr && paddr inside {8'h00, 8'h04} |-> ##2 st1 == $past(ex1, 2))
        else $error("first state wrong");
    second_write_a: assert property (wr && paddr inside {8'h10, 8'h14} |-> ##2 st2 == $past(ex2, 2))
        else $error("second state wrong");
    idle_hold_a: assert property (!$past(wr, 1) && !$past(wr, 2) |-> $stable(st1) && $stable(st2))
        else $error("state moved without write");
endmodule : write_protect_sva
bind peripheral_write_protect_control write_protect_sva u_write_protect_sva
(
    .clk_sys(clk_sys),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .trace_buffer_protect(trace_buffer_protect),
    .port_protect(port_protect),
    .flash_controller_protect(flash_controller_protect),
    .debug_unit_protect(debug_unit_protect),
    .timer_protect(timer_protect),
    .serial_interface_protect(serial_interface_protect),
    .event_system_protect(event_system_protect),
    .converter_protect(converter_protect)
);
`default_nettype wire

// file: tb/peripheral_write_protect_control_bench.sv
// Self-checking bench for the write-protect controller
`timescale 1ns/10ps
`default_nettype none
module peripheral_write_protect_control_bench;
    import write_protect_pkg::*;
    logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, event_system_protect, converter_protect;
    logic trace_buffer_protect, port_protect, flash_controller_protect, debug_unit_protect;
    logic [7:0] paddr, timer_protect;
    logic [5:0] serial_interface_protect;
    logic [31:0] pwdata, prdata, m1, m2;
    logic [31:0] s1, s2;
    logic [96:0] q[$];
    logic [96:0] note;
    logic [7:0] adr[6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h08, 8'hFC};
    int failures, cmp_count;
    peripheral_write_protect_control u_peripheral_write_protect_control
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .trace_buffer_protect(trace_buffer_protect),
        .port_protect(port_protect),
        .flash_controller_protect(flash_controller_protect),
        .debug_unit_protect(debug_unit_protect),
        .timer_protect(timer_protect),
        .serial_interface_protect(serial_interface_protect),
        .event_system_protect(event_system_protect),
        .converter_protect(converter_protect)
    );
    // Protect outputs gathered into the words software would read
    assign s1 = {25'h0, trace_buffer_protect, 2'h0, port_protect, flash_controller_protect, debug_unit_protect, 1'h0};
    assign s2 = {15'h0, converter_protect, timer_protect, serial_interface_protect, event_system_protect, 1'h0};
    // =====
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic end_sim;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // APB transfer; notes the answer and updates the model first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic bad;
        bad = !(a inside {8'h00, 8'h04, 8'h10, 8'h14});
        // Note also the state before this write: outputs lag the commit
        q.push_back({bad, (bad || w) ? ZERO_WORD : (a[4] ? m2 : m1), m1, m2});
        if (w && !bad)
            case (a)
                OFS_FIRST_CLEAR: m1 = m1 & ~(d & FIRST_IMPL_MASK);
                OFS_FIRST_SET: m1 = m1 | (d & FIRST_IMPL_MASK);
                OFS_SECOND_CLEAR: m2 = m2 & ~(d & SECOND_IMPL_MASK);
                default: m2 = m2 | (d & SECOND_IMPL_MASK);
            endcase
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (int i = 0; i < 20 && pready !== 1'b1; i++)
            @(posedge clk_sys);
        if (pready !== 1'b1)
        begin
            failures++;
            end_sim();
        end
        {psel, penable} <= 2'h0;
        @(posedge clk_sys);
    endtask : apb
    // Compare each completed transfer with its note
    always @(posedge clk_sys)
        if (pready === 1'b1)
        begin
            note = q.pop_front();
            chk("prdata", prdata, note[95:64]);
            chk("pslverr", {31'h0, pslverr}, {31'h0, note[96]});
            chk("first_outputs", s1, note[63:32]);
            chk("second_outputs", s2, note[31:0]);
        end
    initial
    begin
        void'($urandom(85730));
        {nrst, psel, penable, pwrite, paddr, pwdata, failures, cmp_count} = '0;
        for (int r = 0; r < 2; r++)
        begin
            {m1, m2} = {FIRST_RESET, SECOND_RESET};
            repeat (16) @(posedge clk_sys);
            nrst <= 1'b1;
            @(posedge clk_sys);
            foreach (adr[i])
                apb(1'b0, adr[i], ZERO_WORD);
            repeat (400)
                apb(1'($urandom_range(0, 1)), adr[$urandom_range(0, 5)], $urandom());
            nrst <= 1'b0;
        end
        end_sim();
    end
endmodule : peripheral_write_protect_control_bench
`default_nettype wire
